// ### logic/card_spi_consts.svh
// Purpose: named offsets, codes and counts of the spi card responder
// Assumes: included by bare name from the design files
// Notes: definitions only
`ifndef CARD_SPI_CONSTS_SVH
`define CARD_SPI_CONSTS_SVH
// apb byte offsets
`define A_CFG 8'h00
`define A_OPCOND 8'h04
`define A_STATUS 8'h08
`define A_ERASE_FIRST 8'h0C
`define A_ERASE_LAST 8'h10
// reset values
`define CFG_RST 32'h0000_4200
`define OPCOND_RST 32'h00FF_8000
// command indices
`define GO_IDLE_CMD 6'h00
`define INIT_CMD 6'h01
`define SEND_DATA_CMD 6'h09
`define SEND_IDENT_CMD 6'h0A
`define STATUS_QUERY_CMD 6'h0D
`define BLOCK_LENGTH_CMD 6'h10
`define READ_ONE_CMD 6'h11
`define READ_MULTI_CMD 6'h12
`define BLOCK_COUNT_CMD 6'h17
`define WRITE_ONE_CMD 6'h18
`define WRITE_MULTI_CMD 6'h19
`define CARD_DATA_PROGRAM_CMD 6'h1B
`define PROTECT_SET_CMD 6'h1C
`define PROTECT_CLEAR_CMD 6'h1D
`define PROTECT_QUERY_CMD 6'h1E
`define ERASE_START_CMD 6'h23
`define ERASE_END_CMD 6'h24
`define ERASE_CMD 6'h26
`define LOCK_CMD 6'h2A
`define OP_CONDITIONS_READ_CMD 6'h3A
`define CRC_OPTION_CMD 6'h3B
// tokens and fill bytes
`define FILL_BYTE 8'hFF
`define BUSY_BYTE 8'h00
`define START_TOKEN 8'hFE
`define MULTI_TOKEN 8'hFC
`define STOP_TOKEN 8'hFD
`define DRESP_OK 8'h05
`define DRESP_CRC 8'h0B
`define DRESP_WERR 8'h0D
// frame layout, byte counts, lock bit and crc polynomials
`define FRAME_HDR 2'h1
`define FRAME_LAST 10'h005
`define PAY_CRC_IX 10'h005
`define PAY_LAST_IX 10'h006
`define OPCOND_BYTES 3'h4
`define LOCK_BIT 2
`define CRC7_POLY 7'h09
`define CRC16_POLY 16'h1021
// busy lengths in bytes
`define BUSY_PROG 8'h04
`define BUSY_WR 8'h02
`define BUSY_ERASE 8'h08
`endif

// ### logic/card_spi_pkg.sv
// Purpose: types shared by the spi card responder
// Assumes: nothing
// Notes: constants live in card_spi_consts.svh
package card_spi_pkg;
	// byte engine states
	typedef enum logic [2:0] {
		ST_CMD = 3'b000, ST_RESP = 3'b001, ST_BUSY = 3'b010,
		ST_TOK = 3'b011, ST_DATA = 3'b100, ST_PAY = 3'b101
	} state_e;
	// one_byte_response, bit 7 first
	typedef struct packed {
		logic zero; logic param_err; logic addr_err; logic erase_seq;
		logic crc_err; logic illegal; logic erase_rst; logic idle;
	} status_byte_s;
	// command frame body
	typedef struct packed {logic [5:0] idx; logic [31:0] arg;} cmd_s;
	// config register, software owned card_specific_data bits
	typedef struct packed {
		logic [16:0] rsvd; logic wp_support; logic write_misalign_allow;
		logic read_misalign_allow; logic [1:0] rsvd1; logic [9:0] dflt_blen;
	} cfg_s;
	// status register view
	typedef struct packed {
		logic [7:0] prog; logic [7:0] erases; logic pad; logic [1:0] erase_stage;
		logic locked; logic crc_en; logic idle; logic [9:0] blen;
	} stat_s;
	// apb request and answer
	typedef struct packed {
		logic psel; logic penable; logic pwrite; logic [7:0] paddr; logic [31:0] pwdata;
	} apb_req_s;
	typedef struct packed {logic pready; logic pslverr; logic [31:0] prdata;} apb_rsp_s;
endpackage

// ### logic/card_spi_command_responder.sv
// Purpose: spi mode command decoder and response engine of a flash card
// Assumes: spi mode 0, sclk much slower than pclk, apb register access
// Notes: user data is counted and checked, not stored
//
// Implementation choices: register access over APB and the register addresses.
`timescale 1ns/1ns
`include "card_spi_consts.svh"
module card_spi_command_responder #(
	parameter int NGRP = 64, // protection groups
	parameter int GRP_SHIFT = 20, // log2 of protect_group_size in bytes
	parameter int MAX_BLEN = 512 // largest block length
)(
	input logic pclk, // system clock
	input logic presetn, // async reset, low
	input card_spi_pkg::apb_req_s apb_req, // apb request
	output card_spi_pkg::apb_rsp_s apb_rsp, // apb answer
	input logic sclk, // spi clock pin
	input logic cs_n, // chip select pin
	input logic mosi, // host to card
	output logic miso, // card to host
	output logic miso_oe_n // miso enable, low drives
);
	import card_spi_pkg::*;

	localparam int GW = $clog2(NGRP); // group index width
	localparam logic [32:0] CAP = 33'(NGRP) << GRP_SHIFT; // capacity in bytes

	////////////////////////////////////////////////////////////////
	// crc helpers
	function automatic logic [6:0] crc7_b(input logic [6:0] c, input logic [7:0] d);
		logic fb;
		for (int i = 7; i >= 0; i--) begin
			fb = c[6] ^ d[i];
			c = {c[5:0], 1'b0} ^ (fb ? `CRC7_POLY : 7'h00);
		end
		return c;
	endfunction

	function automatic logic [15:0] crc16_b(input logic [15:0] c, input logic [7:0] d);
		logic fb;
		for (int i = 7; i >= 0; i--) begin
			fb = c[15] ^ d[i];
			c = {c[14:0], 1'b0} ^ (fb ? `CRC16_POLY : 16'h0000);
		end
		return c;
	endfunction

	////////////////////////////////////////////////////////////////
	// pin synchronisers, first stage read only by second
	logic [2:0] sck_q; // two sync stages plus previous
	logic [1:0] cs_q; // chip select sync
	logic [1:0] mo_q; // mosi sync

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sck_q <= '0;
			cs_q <= '1;
			mo_q <= '1;
		end else begin
			sck_q <= {sck_q[1:0], sclk};
			cs_q <= {cs_q[0], cs_n};
			mo_q <= {mo_q[0], mosi};
		end
	end

	logic rise, fall, sel; // sclk edges, selected
	assign rise = sck_q[1] & ~sck_q[2];
	assign fall = ~sck_q[1] & sck_q[2];
	assign sel = ~cs_q[1];

	////////////////////////////////////////////////////////////////
	// apb registers
	apb_rsp_s rsp_q, rsp_d; // registered answer
	cfg_s cfg_q, cfg_d; // card_specific_data bits
	logic [31:0] opcond_q, opcond_d; // op_conditions_reg
	stat_s stat; // status view
	logic [31:0] erf_q, erl_q; // erase range, core owned
	logic setup, acc; // apb phases

	assign setup = apb_req.psel & ~apb_req.penable;
	assign acc = apb_req.psel & apb_req.penable & rsp_q.pready;

	// answer in the cycle after setup, so access is one cycle long
	always_comb begin
		rsp_d = '0;
		cfg_d = cfg_q;
		opcond_d = opcond_q;
		rsp_d.pready = setup;
		if (setup) begin
			case (apb_req.paddr)
				`A_CFG: rsp_d.prdata = cfg_q;
				`A_OPCOND: rsp_d.prdata = opcond_q;
				`A_STATUS: rsp_d.prdata = stat;
				`A_ERASE_FIRST: rsp_d.prdata = erf_q;
				`A_ERASE_LAST: rsp_d.prdata = erl_q;
				default: rsp_d.pslverr = 1'b1; // unmapped
			endcase
		end
		// writes only at the sampled access edge
		if (acc && apb_req.pwrite) begin
			if (apb_req.paddr == `A_CFG) cfg_d = apb_req.pwdata;
			if (apb_req.paddr == `A_OPCOND) opcond_d = apb_req.pwdata;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rsp_q <= '0;
			cfg_q <= `CFG_RST;
			opcond_q <= `OPCOND_RST;
		end else begin
			rsp_q <= rsp_d;
			cfg_q <= cfg_d;
			opcond_q <= opcond_d;
		end
	end
	assign apb_rsp = rsp_q;

	////////////////////////////////////////////////////////////////
	// core state
	state_e st_q, st_d, aft_q, aft_d, back_q, back_d; // state, after answer, after busy
	logic [2:0] bitc_q, bitc_d; // bit in byte
	logic [7:0] rxsh_q, rxsh_d, txsh_q, txsh_d, nxt_q, nxt_d; // shifters, next byte
	logic ld_q, ld_d; // load next byte at fall
	logic [9:0] cnt_q, cnt_d; // byte index
	logic [39:0] frm_q, frm_d; // frame so far
	logic [6:0] crc7_q, crc7_d; // frame crc
	logic [15:0] crc16_q, crc16_d; // data crc
	logic [31:0] buf_q, buf_d; // answer tail or payload
	logic [2:0] rem_q, rem_d; // answer bytes left
	logic [7:0] busy_q, busy_d; // busy bytes left
	logic idle_q, idle_d, crc_en_q, crc_en_d, locked_q, locked_d;
	logic [1:0] erstg_q, erstg_d; // erase tagging stage
	logic [31:0] erf_d, erl_d, addr_q, addr_d; // erase range, write address
	logic [7:0] ercnt_q, ercnt_d, prog_q, prog_d, lockop_q, lockop_d;
	logic [9:0] blen_q, blen_d, blen; // chosen and effective length
	logic bset_q, bset_d; // length chosen
	logic [15:0] bcnt_q, bcnt_d, left_q, left_d; // preset and remaining blocks
	logic multi_q, multi_d, lock_q, lock_d; // write kind
	logic [NGRP-1:0] wp_q, wp_d; // protection bits
	logic miso_q, miso_d, oe_q, oe_d; // pin flops

	////////////////////////////////////////////////////////////////
	// frame decode helpers
	logic [7:0] b; // byte just completed
	logic rx_done, done, crc_bad, legal, mis, blen_ok, wp_hit, dok;
	logic [47:0] f; // whole frame
	cmd_s cmd;
	logic [31:0] grp, grp_a, pay, g;
	status_byte_s fl; // flags of this answer

	assign b = {rxsh_q[6:0], mo_q[1]};
	assign rx_done = rise & sel & (&bitc_q);
	assign f = {frm_q, b};
	assign cmd = f[45:8];
	assign done = rx_done && st_q == ST_CMD && cnt_q == `FRAME_LAST;
	assign blen = bset_q ? blen_q : cfg_q.dflt_blen;
	// bad end bit counts as a frame crc failure
	assign crc_bad = (crc_en_q && f[7:1] != crc7_q) || !f[0];
	assign grp = cmd.arg >> GRP_SHIFT;
	assign grp_a = addr_q >> GRP_SHIFT;
	assign mis = |(cmd.arg[9:0] & (blen - 10'h001));
	assign blen_ok = cmd.arg != '0 && cmd.arg <= MAX_BLEN && (cmd.arg & (cmd.arg - 32'h0000_0001)) == '0;
	assign wp_hit = grp_a < NGRP && wp_q[grp_a[GW-1:0]];
	assign stat = {prog_q, ercnt_q, 1'b0, erstg_q, locked_q, crc_en_q, idle_q, blen};

	// supported codes; protection needs the feature
	always_comb begin
		case (cmd.idx)
			`GO_IDLE_CMD, `INIT_CMD, `SEND_DATA_CMD, `SEND_IDENT_CMD, `STATUS_QUERY_CMD,
			`BLOCK_LENGTH_CMD, `READ_ONE_CMD, `READ_MULTI_CMD, `BLOCK_COUNT_CMD,
			`WRITE_ONE_CMD, `WRITE_MULTI_CMD, `CARD_DATA_PROGRAM_CMD, `ERASE_START_CMD,
			`ERASE_END_CMD, `ERASE_CMD, `LOCK_CMD, `OP_CONDITIONS_READ_CMD,
			`CRC_OPTION_CMD: legal = 1'b1;
			`PROTECT_SET_CMD, `PROTECT_CLEAR_CMD, `PROTECT_QUERY_CMD: legal = cfg_q.wp_support;
			default: legal = 1'b0;
		endcase
	end

	// protection query payload, first group in bit 0
	always_comb begin
		pay = '0;
		g = '0;
		for (int i = 0; i < 32; i++) begin
			g = grp + 32'(i);
			pay[i] = (g < NGRP) ? wp_q[g[GW-1:0]] : 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////
	// byte engine and command interpreter
	always_comb begin
		st_d = st_q; aft_d = aft_q; back_d = back_q; bitc_d = bitc_q;
		rxsh_d = rxsh_q; txsh_d = txsh_q; nxt_d = nxt_q; ld_d = ld_q;
		cnt_d = cnt_q; frm_d = frm_q; crc7_d = crc7_q; crc16_d = crc16_q;
		buf_d = buf_q; rem_d = rem_q; busy_d = busy_q; idle_d = idle_q;
		crc_en_d = crc_en_q; locked_d = locked_q; erstg_d = erstg_q;
		erf_d = erf_q; erl_d = erl_q; addr_d = addr_q; ercnt_d = ercnt_q;
		prog_d = prog_q; lockop_d = lockop_q; blen_d = blen_q; bset_d = bset_q;
		bcnt_d = bcnt_q; left_d = left_q; multi_d = multi_q; lock_d = lock_q;
		wp_d = wp_q; fl = '0; dok = 1'b0;
		// bit level, out on fall, in on rise
		if (!sel) begin
			bitc_d = '0;
			ld_d = 1'b0;
			txsh_d = `FILL_BYTE;
			if (st_q == ST_CMD) cnt_d = '0; // deselect drops a partial frame
		end else if (rise) begin
			rxsh_d = b;
			bitc_d = bitc_q + 3'h1;
		end else if (fall) begin
			if (ld_q) begin
				txsh_d = nxt_q;
				ld_d = 1'b0;
			end else begin
				txsh_d = {txsh_q[6:0], 1'b1};
			end
		end
		if (rx_done) begin
			ld_d = 1'b1;
			nxt_d = `FILL_BYTE;
			case (st_q)
				// hunt for start and transmission bits, then five more bytes
				ST_CMD: begin
					if (cnt_q != '0 || b[7:6] == `FRAME_HDR) begin
						frm_d = f[39:0];
						cnt_d = cnt_q + 10'h001;
						crc7_d = crc7_b((cnt_q == '0) ? 7'h00 : crc7_q, b);
					end
					if (done) begin
						cnt_d = '0;
						st_d = ST_RESP;
						aft_d = ST_CMD;
						back_d = ST_CMD;
						rem_d = '0;
						if (crc_bad) begin
							fl.crc_err = 1'b1;
						end else if (!legal) begin
							fl.illegal = 1'b1;
						end else begin
							// any other command drops a pending erase
							if (erstg_q != 2'h0 && cmd.idx != `ERASE_START_CMD &&
								cmd.idx != `ERASE_END_CMD && cmd.idx != `ERASE_CMD) begin
								fl.erase_rst = 1'b1;
								erstg_d = 2'h0;
							end
							case (cmd.idx)
								`GO_IDLE_CMD: begin
									idle_d = 1'b1;
									bset_d = 1'b0;
									bcnt_d = '0;
								end
								`INIT_CMD: idle_d = 1'b0; // initialisation done at once
								`BLOCK_LENGTH_CMD: begin
									if (!blen_ok) fl.param_err = 1'b1;
									else begin
										blen_d = cmd.arg[9:0];
										bset_d = 1'b1;
									end
								end
								`BLOCK_COUNT_CMD: begin
									if (|cmd.arg[31:16]) fl.param_err = 1'b1;
									else bcnt_d = cmd.arg[15:0];
								end
								`READ_ONE_CMD, `READ_MULTI_CMD: begin
									if ({1'b0, cmd.arg} >= CAP) fl.param_err = 1'b1;
									else if (mis && !cfg_q.read_misalign_allow) fl.addr_err = 1'b1;
								end
								`WRITE_ONE_CMD, `WRITE_MULTI_CMD: begin
									if ({1'b0, cmd.arg} >= CAP) fl.param_err = 1'b1;
									else if (mis && !cfg_q.write_misalign_allow) fl.addr_err = 1'b1;
									else begin
										aft_d = ST_TOK;
										multi_d = cmd.idx == `WRITE_MULTI_CMD;
										lock_d = 1'b0;
										addr_d = cmd.arg;
										left_d = (cmd.idx == `WRITE_MULTI_CMD) ? bcnt_q : 16'h0001;
										bcnt_d = '0;
									end
								end
								`LOCK_CMD: begin
									aft_d = ST_TOK;
									multi_d = 1'b0;
									lock_d = 1'b1;
									left_d = 16'h0001;
								end
								`CARD_DATA_PROGRAM_CMD: begin
									prog_d = prog_q + 8'h01;
									aft_d = ST_BUSY;
									busy_d = `BUSY_PROG;
								end
								`PROTECT_SET_CMD, `PROTECT_CLEAR_CMD: begin
									if (grp >= NGRP) fl.param_err = 1'b1;
									else begin
										wp_d[grp[GW-1:0]] = cmd.idx == `PROTECT_SET_CMD;
										aft_d = ST_BUSY;
										busy_d = `BUSY_PROG;
									end
								end
								`PROTECT_QUERY_CMD: begin
									aft_d = ST_PAY;
									buf_d = pay;
								end
								`ERASE_START_CMD: begin
									erf_d = cmd.arg;
									erstg_d = 2'h1;
								end
								`ERASE_END_CMD: begin
									if (erstg_q != 2'h1) begin
										fl.erase_seq = 1'b1;
										erstg_d = 2'h0;
									end else begin
										erl_d = cmd.arg;
										erstg_d = 2'h2;
									end
								end
								`ERASE_CMD: begin
									erstg_d = 2'h0;
									if (erstg_q != 2'h2) fl.erase_seq = 1'b1;
									else begin
										ercnt_d = ercnt_q + 8'h01;
										aft_d = ST_BUSY;
										busy_d = `BUSY_ERASE;
									end
								end
								`OP_CONDITIONS_READ_CMD: begin
									rem_d = `OPCOND_BYTES;
									buf_d = opcond_q;
								end
								`CRC_OPTION_CMD: crc_en_d = cmd.arg[0];
								default: ; // answered with the status byte only
							endcase
						end
						fl.idle = idle_d;
						fl.zero = 1'b0;
						nxt_d = fl;
					end
				end
				// remaining answer bytes, then busy or next phase
				ST_RESP: begin
					if (rem_q != '0) begin
						nxt_d = buf_q[31:24];
						buf_d = {buf_q[23:0], 8'h00};
						rem_d = rem_q - 3'h1;
					end else begin
						st_d = aft_q;
						if (aft_q == ST_BUSY) begin
							nxt_d = `BUSY_BYTE;
							busy_d = busy_q - 8'h01;
						end
					end
				end
				// zero bytes while busy, fill byte when done
				ST_BUSY: begin
					if (busy_q != '0) begin
						nxt_d = `BUSY_BYTE;
						busy_d = busy_q - 8'h01;
					end else begin
						st_d = back_q;
					end
				end
				// wait for a data token or the stop token
				ST_TOK: begin
					if (multi_q && b == `STOP_TOKEN) begin
						st_d = ST_BUSY;
						busy_d = `BUSY_WR;
						back_d = ST_CMD;
					end else if (b == (multi_q ? `MULTI_TOKEN : `START_TOKEN)) begin
						st_d = ST_DATA;
						cnt_d = '0;
						crc16_d = '0;
					end
				end
				// block plus crc; good crc leaves a zero residue
				ST_DATA: begin
					crc16_d = crc16_b(crc16_q, b);
					cnt_d = cnt_q + 10'h001;
					if (cnt_q == '0) lockop_d = b;
					if (cnt_q == blen + 10'h001) begin
						dok = crc16_d == '0 || !crc_en_q;
						if (!dok) nxt_d = `DRESP_CRC;
						else if (!lock_q && wp_hit) nxt_d = `DRESP_WERR;
						else nxt_d = `DRESP_OK;
						if (dok && lock_q) locked_d = lockop_q[`LOCK_BIT];
						st_d = ST_BUSY;
						busy_d = `BUSY_WR;
						addr_d = addr_q + 32'(blen);
						if (left_q == 16'h0001) back_d = ST_CMD;
						else begin
							back_d = ST_TOK;
							if (left_q != '0) left_d = left_q - 16'h0001;
						end
					end
				end
				// token, four payload bytes, two crc bytes
				ST_PAY: begin
					cnt_d = cnt_q + 10'h001;
					if (cnt_q == '0) begin
						nxt_d = `START_TOKEN;
						crc16_d = '0;
					end else if (cnt_q < `PAY_CRC_IX) begin
						nxt_d = buf_q[31:24];
						buf_d = {buf_q[23:0], 8'h00};
						crc16_d = crc16_b(crc16_q, buf_q[31:24]);
					end else if (cnt_q == `PAY_CRC_IX) begin
						nxt_d = crc16_q[15:8];
					end else begin
						nxt_d = crc16_q[7:0];
						st_d = ST_CMD;
						cnt_d = '0;
					end
				end
				default: st_d = ST_CMD;
			endcase
		end
		miso_d = txsh_d[7];
		oe_d = cs_q[1];
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_q <= ST_CMD; aft_q <= ST_CMD; back_q <= ST_CMD; bitc_q <= '0;
			rxsh_q <= '0; txsh_q <= `FILL_BYTE; nxt_q <= `FILL_BYTE; ld_q <= 1'b0;
			cnt_q <= '0; frm_q <= '0; crc7_q <= '0; crc16_q <= '0; buf_q <= '0;
			rem_q <= '0; busy_q <= '0; idle_q <= 1'b1; crc_en_q <= 1'b0;
			locked_q <= 1'b0; erstg_q <= '0; erf_q <= '0; erl_q <= '0; addr_q <= '0;
			ercnt_q <= '0; prog_q <= '0; lockop_q <= '0; blen_q <= '0; bset_q <= 1'b0;
			bcnt_q <= '0; left_q <= '0; multi_q <= 1'b0; lock_q <= 1'b0; wp_q <= '0;
			miso_q <= 1'b1; oe_q <= 1'b1;
		end else begin
			st_q <= st_d; aft_q <= aft_d; back_q <= back_d; bitc_q <= bitc_d;
			rxsh_q <= rxsh_d; txsh_q <= txsh_d; nxt_q <= nxt_d; ld_q <= ld_d;
			cnt_q <= cnt_d; frm_q <= frm_d; crc7_q <= crc7_d; crc16_q <= crc16_d; buf_q <= buf_d;
			rem_q <= rem_d; busy_q <= busy_d; idle_q <= idle_d; crc_en_q <= crc_en_d;
			locked_q <= locked_d; erstg_q <= erstg_d; erf_q <= erf_d; erl_q <= erl_d; addr_q <= addr_d;
			ercnt_q <= ercnt_d; prog_q <= prog_d; lockop_q <= lockop_d; blen_q <= blen_d; bset_q <= bset_d;
			bcnt_q <= bcnt_d; left_q <= left_d; multi_q <= multi_d; lock_q <= lock_d; wp_q <= wp_d;
			miso_q <= miso_d; oe_q <= oe_d;
		end
	end
	assign miso = miso_q;
	assign miso_oe_n = oe_q;

	////////////////////////////////////////////////////////////////
	// checks
	a_resp_msb: assert property (@(posedge pclk) disable iff (!presetn)
		done |=> !nxt_q[7] && st_q == ST_RESP) else $error("answer msb not zero");
	a_crc_option: assert property (@(posedge pclk) disable iff (!presetn)
		done && !crc_bad && cmd.idx == `CRC_OPTION_CMD |=> crc_en_q == $past(f[8]))
		else $error("crc option not applied");
	a_illegal_flag: assert property (@(posedge pclk) disable iff (!presetn)
		done && !crc_bad && !legal |=> nxt_q == 8'h04 || nxt_q == 8'h05) else $error("illegal not flagged");
	a_crc_flag: assert property (@(posedge pclk) disable iff (!presetn)
		done && crc_bad |=> nxt_q[3] && $stable(wp_q)) else $error("crc error not flagged");
	a_busy_zero: assert property (@(posedge pclk) disable iff (!presetn)
		rx_done && st_q == ST_BUSY && busy_q != '0 |=> nxt_q == `BUSY_BYTE) else $error("busy not zero");
	a_msb_first: assert property (@(posedge pclk) disable iff (!presetn)
		fall && sel && !ld_q |=> miso_q == $past(txsh_q[6])) else $error("bit order wrong");
	a_erase_order: assert property (@(posedge pclk) disable iff (!presetn)
		done && !crc_bad && cmd.idx == `ERASE_CMD && erstg_q != 2'h2 |=> nxt_q[4] && erstg_q == 2'h0)
		else $error("erase order not flagged");
	a_data_resp: assert property (@(posedge pclk) disable iff (!presetn)
		rx_done && st_q == ST_DATA && cnt_q == blen + 10'h001 |=>
		(nxt_q == `DRESP_OK || nxt_q == `DRESP_CRC || nxt_q == `DRESP_WERR) && st_q == ST_BUSY)
		else $error("data response bad");
	a_default_len: assert property (@(posedge pclk) disable iff (!presetn)
		done && !crc_bad && cmd.idx == `GO_IDLE_CMD |=> blen == cfg_q.dflt_blen && idle_q)
		else $error("default length not used");
endmodule // card_spi_command_responder

// ### verification/spi_host_model.sv
// Purpose: spi host controller driving the card, mode 0
// Assumes: link clock of 400 ns, low between frames
// Notes: paced by pclk, 8 pclk per link bit; mosi returns high on release
`timescale 1ns/1ns
module spi_host_model (
	input wire logic pclk, // bench clock, paces every pin change
	output logic sclk, // link clock
	output logic cs_n, // chip select, low selects
	output logic mosi, // host to card
	input wire logic miso // card to host
);
	initial begin
		sclk = 1'b0;
		cs_n = 1'b1;
		mosi = 1'b1;
	end
	// one byte each way, msb first; change while low, sample on rise
	// pins move only by nba at a pclk edge, 400 ns per bit
	task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
		for (int i = 7; i >= 0; i--) begin
			mosi <= tx[i];
			repeat (2) @(posedge pclk);
			sclk <= 1'b1;
			rx[i] = miso; // value standing at the rise
			repeat (4) @(posedge pclk);
			sclk <= 1'b0;
			repeat (2) @(posedge pclk);
		end
	endtask
	// start and transmission bits, index, argument, crc with end bit
	task automatic cmd(input logic [5:0] idx, input logic [31:0] arg, input logic [7:0] crc);
		logic [47:0] f;
		logic [7:0] r;
		f = {2'b01, idx, arg, crc};
		@(posedge pclk);
		cs_n <= 1'b0;
		repeat (8) @(posedge pclk);
		for (int k = 0; k < 6; k++) xfer(f[47 - 8 * k -: 8], r);
	endtask
	// release the card; the clock has stood low since the last byte
	task automatic desel;
		repeat (8) @(posedge pclk);
		cs_n <= 1'b1;
		mosi <= 1'b1;
		repeat (8) @(posedge pclk);
	endtask
endmodule // spi_host_model

// ### verification/tb.sv
// Purpose: self-checking bench of the spi card responder
// Assumes: default parameters, crc checking off until command 59
// Notes: expectations queue up, a monitor compares them in order
`timescale 1ns/1ns
`include "card_spi_consts.svh"
`define CHK(e, a) begin checks_done++; if ((a) !== (e)) begin n_mismatch++; \
	$display("Error %s expected %h seen %h", nm, e, a); end end
module tb;
	import card_spi_pkg::*;
	logic pclk, presetn, sclk, cs_n, mosi, miso, err; // pins
	logic miso_pin, oe_n; // card side of the data line
	logic [7:0] d8; // byte echoed while sending data
	apb_req_s req; // apb request
	apb_rsp_s rsp; // apb answer
	logic [31:0] exp_q[$]; // pending expectations
	logic [31:0] got, ex, rnd, r; // results and random word
	string nm; // name of what was checked
	event ev; // a result has appeared
	int n_mismatch, checks_done;
	card_spi_command_responder dut (.pclk(pclk), .presetn(presetn), .apb_req(req), .apb_rsp(rsp),
		.sclk(sclk), .cs_n(cs_n), .mosi(mosi), .miso(miso_pin), .miso_oe_n(oe_n));
	// pull-up holds the line high whenever the card lets go of it
	assign miso = oe_n ? 1'b1 : miso_pin;
	spi_host_model host (.pclk(pclk), .sclk(sclk), .cs_n(cs_n), .mosi(mosi), .miso(miso));
	initial begin
		pclk = 1'b0;
		forever #25 pclk = ~pclk;
	end
	////////////////////////////////////////////////////////////////
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	task results;
		if (n_mismatch == 0 && checks_done > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	// hand a result to the monitor; one clock keeps results apart
	task see(input string n, input logic [31:0] v);
		nm = n;
		got = v;
		->ev;
		@(posedge pclk);
	endtask
	// apb transfer; waits for pready under a bound
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int i;
		@(posedge pclk);
		req <= '{1'b1, 1'b0, w, a, d};
		@(posedge pclk);
		req.penable <= 1'b1;
		for (i = 0; i < 20; i++) begin
			@(posedge pclk);
			if (rsp.pready === 1'b1) break;
		end
		r = rsp.prdata;
		err = rsp.pslverr;
		req <= '0;
		if (i == 20) begin
			n_mismatch++;
			results;
		end
	endtask
	task rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
		exp_q.push_back(e);
		apb(1'b0, a, 32'h0);
		see("prdata", r & m);
	endtask
	task byte_chk(input logic [7:0] e);
		logic [7:0] b;
		exp_q.push_back({24'h0, e});
		host.xfer(`FILL_BYTE, b);
		see("miso byte", {24'h0, b});
	endtask
	// monitor: oldest expectation against each result
	initial forever begin
		@ev;
		ex = exp_q.pop_front();
		`CHK(ex, got)
	end
	////////////////////////////////////////////////////////////////
	initial begin
		req = '0;
		presetn = 1'b0;
		rnd = 32'd21;
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		rd(`A_CFG, `CFG_RST, '1);
		rd(8'h14, 32'h0, '1);
		exp_q.push_back(32'h1);
		see("pslverr", {31'h0, err});
		rnd = lfsr(lfsr(rnd));
		apb(1'b1, `A_OPCOND, rnd);
		host.cmd(`OP_CONDITIONS_READ_CMD, 32'h0, 8'h01);
		byte_chk(8'h01);
		for (int k = 3; k >= 0; k--) byte_chk(rnd[8 * k +: 8]);
		host.desel;
		host.cmd(6'h02, 32'h0, 8'h01);
		byte_chk(8'h05);
		host.desel;
		host.cmd(`BLOCK_LENGTH_CMD, 32'h0000_0010, 8'h01);
		byte_chk(8'h01);
		host.desel;
		rd(`A_STATUS, 32'h0000_0010, 32'h0000_03FF);
		host.cmd(`WRITE_ONE_CMD, 32'h0000_0020, 8'h01);
		byte_chk(8'h01);
		host.xfer(`START_TOKEN, d8);
		// sixteen random data bytes, then two crc bytes; crc still off
		for (int k = 0; k < 18; k++) begin
			rnd = lfsr(rnd);
			host.xfer(rnd[7:0], d8);
		end
		byte_chk(`DRESP_OK);
		repeat (2) byte_chk(`BUSY_BYTE);
		byte_chk(`FILL_BYTE);
		host.desel;
		host.cmd(`GO_IDLE_CMD, 32'h0, 8'h01);
		byte_chk(8'h01);
		host.desel;
		rd(`A_STATUS, 32'h0000_0200, 32'h0000_03FF);
		host.cmd(`INIT_CMD, 32'h0, 8'h01);
		byte_chk(8'h00);
		host.desel;
		rd(`A_STATUS, 32'h0, 32'h0000_0400);
		host.cmd(`CARD_DATA_PROGRAM_CMD, 32'h0, 8'h01);
		byte_chk(8'h00);
		repeat (4) byte_chk(`BUSY_BYTE);
		byte_chk(`FILL_BYTE);
		host.desel;
		host.cmd(`ERASE_START_CMD, 32'h0000_0200, 8'h01);
		byte_chk(8'h00);
		host.desel;
		host.cmd(`ERASE_END_CMD, 32'h0000_0400, 8'h01);
		byte_chk(8'h00);
		host.desel;
		rd(`A_ERASE_FIRST, 32'h0000_0200, '1);
		rd(`A_ERASE_LAST, 32'h0000_0400, '1);
		host.cmd(`ERASE_CMD, 32'h0, 8'h01);
		byte_chk(8'h00);
		repeat (8) byte_chk(`BUSY_BYTE);
		byte_chk(`FILL_BYTE);
		host.desel;
		host.cmd(`CRC_OPTION_CMD, 32'h1, 8'h01);
		byte_chk(8'h00);
		host.desel;
		rd(`A_STATUS, 32'h0000_0800, 32'h0000_0800);
		host.cmd(`SEND_DATA_CMD, 32'h0, 8'h01);
		byte_chk(8'h08);
		host.desel;
		results;
	end
endmodule // tb
